// ===== include/hpi_pkg.sv
// Constants and carrier types for the host port indirect access block
// Assumes one 50 MHz clock and an asynchronous active-low reset
package hpi_pkg;

    // ==========================================================
    // Direct register offsets
    localparam logic [7:0] HPI_ADR_SUMMARY  = 8'h29;
    localparam logic [7:0] HPI_ADR_ADDR_TOP = 8'h30;
    localparam logic [7:0] HPI_ADR_ADDR_UPP = 8'h31;
    localparam logic [7:0] HPI_ADR_ADDR_MID = 8'h32;
    localparam logic [7:0] HPI_ADR_ADDR_LOW = 8'h33;
    localparam logic [7:0] HPI_ADR_CONTROL  = 8'h34;
    localparam logic [7:0] HPI_ADR_DATA_HI  = 8'h35;
    localparam logic [7:0] HPI_ADR_DATA_LO  = 8'h36;
    localparam logic [7:0] HPI_ADR_INT_EN   = 8'h37;

    // ==========================================================
    // Control register fields: start bit7, codes 6:5, addr 4:0
    localparam int HPI_CTL_START = 7;
    localparam int HPI_CTL_WE_HI = 6;
    localparam int HPI_CTL_WE_LO = 5;
    localparam logic [1:0] HPI_WE_READ = 2'h0;

    // Summary bits
    localparam int HPI_SUM_MAIN  = 0;
    localparam int HPI_SUM_UTOP  = 1;
    localparam int HPI_SUM_SDRAM = 2;
    localparam int HPI_SUM_SENT  = 3;
    localparam int HPI_SUM_AVAIL = 4;
    localparam int HPI_NUM_SRC   = 5;

    // ==========================================================
    // Timing
    localparam int HPI_CLK_MHZ     = 50;
    localparam int HPI_ACK_CYC     = 4;
    localparam int HPI_EXT_CYC     = 6;
    localparam logic [7:0] HPI_RD_DEFAULT = 8'h00;

    typedef struct packed {
        logic       sel_n;
        logic       wr_strobe_n;
        logic       rd_dir_n;
        logic [7:0] addr;
        logic [7:0] data;
    } hpi_pins_t;

    typedef struct packed {
        logic [24:0] addr;
        logic [1:0]  we;
        logic [15:0] wdata;
    } hpi_ext_req_t;

endpackage

// ===== src/hpi_host_port.sv
// Byte-wide processor port with direct and indirect register access
// Assumes processor pins are asynchronous; extended memory answers
// each request with a one-cycle done pulse and read data
`timescale 1ns/1ps
module hpi_host_port #(
    parameter int EXT_WAIT = hpi_pkg::HPI_EXT_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        style_strobe_i,
    input  wire logic        mux_shared_i,
    input  wire logic        sel_n_i,
    input  wire logic        write_or_strobe_n_i,
    input  wire logic        rd_dir_n_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  data_i,
    output logic      [7:0]  data_o,
    output logic             data_oe_o,
    output logic             ack_o,
    output logic             ack_oe_o,
    output logic             irq_o,
    input  wire logic [2:0]  group_status_i,
    input  wire logic        cell_sent_i,
    input  wire logic        control_cell_waiting_i,
    output logic             ext_req_o,
    output logic [24:0]      ext_addr_o,
    output logic [1:0]       ext_we_o,
    output logic [15:0]      ext_wdata_o,
    input  wire logic        ext_done_i,
    input  wire logic [15:0] ext_rdata_i
);

    // ==========================================================
    // Parameter check; the wait counter is eight bits wide
    if (EXT_WAIT < 1 || EXT_WAIT > 256) begin
        $error("EXT_WAIT must lie between 1 and 256");
    end

    // ==========================================================
    // Pin synchronisers
    hpi_pkg::hpi_pins_t meta_r;
    hpi_pkg::hpi_pins_t pin_r;
    logic [1:0]         cfg_meta_r;
    logic [1:0]         cfg_r;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_r     <= '{sel_n: 1'b1, wr_strobe_n: 1'b1,
                            rd_dir_n: 1'b1, default: '0};
            pin_r      <= '{sel_n: 1'b1, wr_strobe_n: 1'b1,
                            rd_dir_n: 1'b1, default: '0};
            cfg_meta_r <= 2'h0;
            cfg_r      <= 2'h0;
        end else begin
            meta_r     <= '{sel_n: sel_n_i,
                            wr_strobe_n: write_or_strobe_n_i,
                            rd_dir_n: rd_dir_n_i,
                            addr: addr_i, data: data_i};
            pin_r      <= meta_r;
            cfg_meta_r <= {style_strobe_i, mux_shared_i};
            cfg_r      <= cfg_meta_r;
        end
    end

    logic strobe_mode;
    logic shared_mode;
    assign strobe_mode = cfg_r[1];
    assign shared_mode = cfg_r[0];

    // ==========================================================
    // Access decode
    logic is_rd;
    logic is_wr;
    logic active;
    logic idle_pins;
    always_comb begin
        if (strobe_mode) begin
            is_rd = !pin_r.wr_strobe_n && pin_r.rd_dir_n;
            is_wr = !pin_r.wr_strobe_n && !pin_r.rd_dir_n;
        end else begin
            is_rd = !pin_r.rd_dir_n && pin_r.wr_strobe_n;
            is_wr = !pin_r.wr_strobe_n && pin_r.rd_dir_n;
        end
        active    = !pin_r.sel_n && (is_rd || is_wr);
        // Data leads float unless a read is strobed with select low
        idle_pins = pin_r.sel_n || !is_rd;
    end

    // Shared-mode address latch on a0 strobe
    logic [7:0] mux_addr_r;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mux_addr_r <= 8'h00;
        end else if (shared_mode && pin_r.addr[0]) begin
            mux_addr_r <= pin_r.data;
        end
    end

    logic [7:0] acc_addr;
    assign acc_addr = shared_mode ? mux_addr_r : pin_r.addr;

    // ==========================================================
    // Access sequencer
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} hpi_st_t;
    hpi_st_t    st_r;
    logic [2:0] cyc_r;
    logic       take;
    logic       rel;

    assign take = (st_r == ST_WAIT)
                  && (cyc_r == 3'(hpi_pkg::HPI_ACK_CYC - 1));
    assign rel  = pin_r.sel_n || (strobe_mode ? pin_r.wr_strobe_n
                  : (pin_r.wr_strobe_n && pin_r.rd_dir_n));

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r  <= ST_IDLE;
            cyc_r <= 3'h0;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    cyc_r <= 3'h0;
                    if (active) begin
                        st_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    cyc_r <= cyc_r + 3'h1;
                    if (rel) begin
                        st_r <= ST_IDLE;
                    end else if (take) begin
                        st_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (rel) begin
                        st_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    logic wr_take;
    assign wr_take = take && is_wr;

    // ==========================================================
    // Indirect registers
    logic [7:0]  a_top_r;
    logic [7:0]  a_upp_r;
    logic [7:0]  a_mid_r;
    logic [7:0]  a_low_r;
    logic [7:0]  ctl_r;
    logic [7:0]  d_hi_r;
    logic [7:0]  d_lo_r;
    localparam int HPI_EN_W = hpi_pkg::HPI_NUM_SRC;
    logic [HPI_EN_W-1:0] int_en_r;
    logic        ext_busy_r;
    logic [7:0]  ext_cnt_r;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            a_top_r  <= 8'h00;
            a_upp_r  <= 8'h00;
            a_mid_r  <= 8'h00;
            a_low_r  <= 8'h00;
            int_en_r <= '0;
        end else if (wr_take) begin
            unique case (acc_addr)
                hpi_pkg::HPI_ADR_ADDR_TOP: a_top_r <= pin_r.data;
                hpi_pkg::HPI_ADR_ADDR_UPP: a_upp_r <= pin_r.data;
                hpi_pkg::HPI_ADR_ADDR_MID: a_mid_r <= pin_r.data;
                hpi_pkg::HPI_ADR_ADDR_LOW: a_low_r <= pin_r.data;
                hpi_pkg::HPI_ADR_INT_EN:
                    int_en_r <= pin_r.data[HPI_EN_W-1:0];
                default: ;
            endcase
        end
    end

    // Control register; hardware clears start when the word is done
    logic start_wr;
    assign start_wr = wr_take && (acc_addr == hpi_pkg::HPI_ADR_CONTROL)
                      && !ctl_r[hpi_pkg::HPI_CTL_START];
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctl_r <= 8'h00;
        end else if (start_wr) begin
            ctl_r <= pin_r.data;
        end else if (ext_done_i && ext_busy_r) begin
            ctl_r[hpi_pkg::HPI_CTL_START] <= 1'b0;
        end
    end

    // Data registers: written by processor or by read completion
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            d_hi_r <= 8'h00;
            d_lo_r <= 8'h00;
        end else if (ext_done_i && ext_busy_r
                     && ext_we_o == hpi_pkg::HPI_WE_READ) begin
            d_hi_r <= ext_rdata_i[15:8];
            d_lo_r <= ext_rdata_i[7:0];
        end else if (wr_take
                     && acc_addr == hpi_pkg::HPI_ADR_DATA_HI) begin
            d_hi_r <= pin_r.data;
        end else if (wr_take
                     && acc_addr == hpi_pkg::HPI_ADR_DATA_LO) begin
            d_lo_r <= pin_r.data;
        end
    end

    // ==========================================================
    // Extended word request
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_busy_r  <= 1'b0;
            ext_req_o   <= 1'b0;
            ext_addr_o  <= 25'h0;
            ext_we_o    <= 2'h0;
            ext_wdata_o <= 16'h0;
            ext_cnt_r   <= 8'h00;
        end else begin
            ext_req_o <= 1'b0;
            if (start_wr && pin_r.data[hpi_pkg::HPI_CTL_START]) begin
                ext_busy_r  <= 1'b1;
                ext_cnt_r   <= 8'h00;
                ext_addr_o  <= {a_top_r[0], a_upp_r, a_mid_r,
                                a_low_r[2:0], pin_r.data[4:0]};
                ext_we_o    <= pin_r.data[hpi_pkg::HPI_CTL_WE_HI:
                                          hpi_pkg::HPI_CTL_WE_LO];
                ext_wdata_o <= {d_hi_r, d_lo_r};
            end else if (ext_busy_r) begin
                if (ext_cnt_r == 8'(EXT_WAIT - 1)) begin
                    ext_req_o <= 1'b1;
                end
                if (ext_cnt_r != 8'hff) begin
                    ext_cnt_r <= ext_cnt_r + 8'h01;
                end
                if (ext_done_i) begin
                    ext_busy_r <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Interrupt summary
    logic [4:0] summary_r;
    logic [4:0] src;
    assign src = {control_cell_waiting_i, cell_sent_i,
                  group_status_i};
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            summary_r <= 5'h00;
        end else begin
            summary_r <= src & int_en_r;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (|summary_r) ^ strobe_mode;
        end
    end

    // ==========================================================
    // Read data and pin drivers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_o <= 8'h00;
        end else if (take && is_rd) begin
            unique case (acc_addr)
                hpi_pkg::HPI_ADR_SUMMARY:  data_o <= {3'h0, summary_r};
                hpi_pkg::HPI_ADR_ADDR_TOP: data_o <= a_top_r;
                hpi_pkg::HPI_ADR_ADDR_UPP: data_o <= a_upp_r;
                hpi_pkg::HPI_ADR_ADDR_MID: data_o <= a_mid_r;
                hpi_pkg::HPI_ADR_ADDR_LOW: data_o <= a_low_r;
                hpi_pkg::HPI_ADR_CONTROL:  data_o <= ctl_r;
                hpi_pkg::HPI_ADR_DATA_HI:  data_o <= d_hi_r;
                hpi_pkg::HPI_ADR_DATA_LO:  data_o <= d_lo_r;
                hpi_pkg::HPI_ADR_INT_EN:   data_o <= {3'h0, int_en_r};
                default: data_o <= hpi_pkg::HPI_RD_DEFAULT;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_oe_o <= 1'b0;
            ack_o     <= 1'b0;
            ack_oe_o  <= 1'b0;
        end else begin
            data_oe_o <= (st_r == ST_DONE || take) && is_rd
                         && !idle_pins;
            if (strobe_mode) begin
                if (take || (st_r == ST_DONE && !rel)) begin
                    ack_o    <= 1'b0;
                    ack_oe_o <= 1'b1;
                end else if (st_r == ST_DONE && rel && !ack_o) begin
                    ack_o    <= 1'b1;
                    ack_oe_o <= 1'b1;
                end else begin
                    ack_o    <= 1'b1;
                    ack_oe_o <= 1'b0;
                end
            end else begin
                ack_o    <= take || (st_r == ST_DONE && !rel);
                ack_oe_o <= take || (st_r == ST_DONE && !rel);
            end
        end
    end

endmodule

// ===== tb/hpi_host_port_assertions.sv
// Port-level checker for the host port block
// Assumes it is bound into every hpi_host_port instance
`timescale 1ns/1ps
module hpi_host_port_assertions #(
    parameter int EXT_WAIT = hpi_pkg::HPI_EXT_CYC
) (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        style_strobe_i,
    input wire logic        mux_shared_i,
    input wire logic        sel_n_i,
    input wire logic        write_or_strobe_n_i,
    input wire logic        rd_dir_n_i,
    input wire logic [7:0]  addr_i,
    input wire logic [7:0]  data_i,
    input wire logic [7:0]  data_o,
    input wire logic        data_oe_o,
    input wire logic        ack_o,
    input wire logic        ack_oe_o,
    input wire logic        irq_o,
    input wire logic [2:0]  group_status_i,
    input wire logic        cell_sent_i,
    input wire logic        control_cell_waiting_i,
    input wire logic        ext_req_o,
    input wire logic [24:0] ext_addr_o,
    input wire logic [1:0]  ext_we_o,
    input wire logic [15:0] ext_wdata_o,
    input wire logic        ext_done_i,
    input wire logic [15:0] ext_rdata_i
);
    // ==========================================================
    // Settle counter after reset
    logic [3:0] up_cnt_r;
    logic       up_ok;
    logic       any_st;
    assign up_ok  = up_cnt_r[3];
    assign any_st = (|group_status_i) | cell_sent_i | control_cell_waiting_i;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i)
            up_cnt_r <= 4'h0;
        else if (!up_ok)
            up_cnt_r <= up_cnt_r + 4'h1;
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_data_hiz: assert property (
        sel_n_i [*6] |-> !data_oe_o && !ack_oe_o)
        else $error("pins driven while not selected");
    a_ready_high: assert property (
        ack_oe_o && !style_strobe_i |-> ack_o)
        else $error("ready not high while driven");
    a_ack_low_first: assert property (
        style_strobe_i && $rose(ack_oe_o) |-> !ack_o)
        else $error("acknowledge not low when driven");
    a_ack_high_release: assert property (
        style_strobe_i && $fell(ack_oe_o) |-> $past(ack_o))
        else $error("acknowledge not high before release");
    a_ack_release: assert property (
        $rose(sel_n_i) |-> ##[1:6] !ack_oe_o)
        else $error("acknowledge not released");
    a_irq_rest: assert property (
        (up_ok && !any_st) [*4] |-> irq_o == style_strobe_i)
        else $error("interrupt not at rest level");
    a_irq_cause: assert property (
        up_ok && irq_o != style_strobe_i |-> $past(any_st) ||
        $past(any_st, 2) || $past(any_st, 3) || $past(any_st, 4))
        else $error("interrupt without status");
    a_req_single: assert property (
        ext_req_o |=> !ext_req_o)
        else $error("request longer than one cycle");
    a_req_hold: assert property (
        ext_req_o |=> ($stable(ext_addr_o) && $stable(ext_we_o)) [*4])
        else $error("request fields changed");

    c_ext_read: cover property (ext_req_o && ext_we_o == 2'h0);
    c_strobe_ack: cover property (style_strobe_i && $fell(ack_oe_o));
    c_irq: cover property (up_ok && irq_o != style_strobe_i);
endmodule

bind hpi_host_port hpi_host_port_assertions #(.EXT_WAIT(EXT_WAIT))
    hpi_host_port_assertions_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .style_strobe_i(style_strobe_i),
    .mux_shared_i(mux_shared_i), .sel_n_i(sel_n_i),
    .write_or_strobe_n_i(write_or_strobe_n_i), .rd_dir_n_i(rd_dir_n_i),
    .addr_i(addr_i), .data_i(data_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .ack_o(ack_o), .ack_oe_o(ack_oe_o),
    .irq_o(irq_o), .group_status_i(group_status_i),
    .cell_sent_i(cell_sent_i),
    .control_cell_waiting_i(control_cell_waiting_i),
    .ext_req_o(ext_req_o), .ext_addr_o(ext_addr_o), .ext_we_o(ext_we_o),
    .ext_wdata_o(ext_wdata_o), .ext_done_i(ext_done_i),
    .ext_rdata_i(ext_rdata_i));

// ===== tb/hpi_proc_model.sv
// Processor bus master driving the host port pins
// Assumes tb calls xfer; pins change at falling edges only
`timescale 1ns/1ps
module hpi_proc_model (
    input  wire logic       clk_i,
    input  wire logic       strb_i,
    input  wire logic       mux_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       ack_i,
    input  wire logic       ack_oe_i,
    input  wire logic       data_oe_i,
    output logic            sel_n_o,
    output logic            wr_n_o,
    output logic            rd_n_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] data_o
);
    initial begin
        sel_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        addr_o = 8'h00;
        data_o = 8'h00;
    end

    // ==========================================================
    // One access, held until completion is seen
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q, output logic ok);
        int n;
        n = 0;
        @(negedge clk_i);
        if (mux_i) begin
            data_o = a;
            addr_o = 8'h01;
            repeat (3) @(negedge clk_i);
            addr_o = 8'h00;
            @(negedge clk_i);
        end else
            addr_o = a;
        data_o = w ? d : ~data_o;
        sel_n_o = 1'b0;
        wr_n_o = strb_i ? 1'b0 : !w;
        rd_n_o = strb_i ? !w : w;
        while ((ack_oe_i !== 1'b1 || ack_i !== !strb_i) && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        q = data_oe_i === 1'b1 ? rdata_i : 8'hxx;
        ok = n < 40;
        sel_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        data_o = ~data_o;
        n = 0;
        while (ack_oe_i !== 1'b0 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        ok = ok && n < 20;
    endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the host port block
// Assumes hpi_proc_model drives pins; memory is modelled here
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0, nrst_i = 1'b0, style_strobe_i = 1'b0;
    logic mux_shared_i = 1'b0, cell_sent_i = 1'b0, ext_done_i = 1'b0;
    logic control_cell_waiting_i = 1'b0, sel_n_i, write_or_strobe_n_i;
    logic rd_dir_n_i, data_oe_o, ack_o, ack_oe_o, irq_o, ext_req_o;
    logic [2:0] group_status_i = 3'h0;
    logic [7:0] addr_i, data_i, data_o;
    logic [24:0] ext_addr_o;
    logic [1:0] ext_we_o;
    logic [15:0] ext_wdata_o, ext_rdata_i = 16'h0000;
    hpi_pkg::hpi_ext_req_t cap;
    int err_count = 0, n_compared = 0, due = 0;

    always #10 clk_i = ~clk_i;
    hpi_host_port #(.EXT_WAIT(2)) hpi_host_port_i (
        .clk_i(clk_i), .nrst_i(nrst_i), .style_strobe_i(style_strobe_i),
        .mux_shared_i(mux_shared_i), .sel_n_i(sel_n_i),
        .write_or_strobe_n_i(write_or_strobe_n_i),
        .rd_dir_n_i(rd_dir_n_i),
        .addr_i(addr_i), .data_i(data_i), .data_o(data_o),
        .data_oe_o(data_oe_o), .ack_o(ack_o), .ack_oe_o(ack_oe_o),
        .irq_o(irq_o), .group_status_i(group_status_i),
        .cell_sent_i(cell_sent_i),
        .control_cell_waiting_i(control_cell_waiting_i),
        .ext_req_o(ext_req_o), .ext_addr_o(ext_addr_o),
        .ext_we_o(ext_we_o), .ext_wdata_o(ext_wdata_o),
        .ext_done_i(ext_done_i), .ext_rdata_i(ext_rdata_i));
    hpi_proc_model hpi_proc_model_i (.clk_i(clk_i), .strb_i(style_strobe_i),
        .mux_i(mux_shared_i), .rdata_i(data_o), .ack_i(ack_o),
        .ack_oe_i(ack_oe_o), .sel_n_o(sel_n_i), .wr_n_o(write_or_strobe_n_i),
        .rd_n_o(rd_dir_n_i), .addr_o(addr_i), .data_o(data_i),
        .data_oe_i(data_oe_o));

    // ==========================================================
    // Extended memory: captures request, done two cycles later
    always @(negedge clk_i) begin
        if (ext_req_o === 1'b1) begin
            cap = {ext_addr_o, ext_we_o, ext_wdata_o};
            due = 3;
        end else if (due > 0)
            due--;
        ext_done_i = due == 1;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, d,
                       output logic [7:0] q);
        logic ok;
        hpi_proc_model_i.xfer(w, a, d, q, ok);
        chk("handshake", 32'h1, {31'h0, ok});
        if (ok !== 1'b1) begin
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, e);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk("read data", {24'h0, e}, {24'h0, q});
    endtask
    task automatic poll();
        logic [7:0] q;
        int n;
        q = 8'h80;
        n = 0;
        while (q[7] !== 1'b0 && n < 20) begin
            acc(1'b0, hpi_pkg::HPI_ADR_CONTROL, 8'h00, q);
            n++;
        end
        chk("start cleared", 32'h0, {31'h0, q[7]});
        if (q[7] !== 1'b0) begin
            stop_test();
        end
    endtask
    task automatic rst(input logic s, m);
        @(negedge clk_i);
        nrst_i = 1'b0;
        style_strobe_i = s;
        mux_shared_i = m;
        repeat (8) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (50) @(negedge clk_i);
    endtask
    task automatic wait_chk(input string nm, input logic e);
        repeat (8) @(negedge clk_i);
        chk(nm, {31'h0, e}, {31'h0, irq_o});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_ext_write();
        logic [1:0] we;
        for (int i = 1; i < 4; i++) begin
            we = 2'(i);
            wr(hpi_pkg::HPI_ADR_ADDR_TOP, 8'h01);
            wr(hpi_pkg::HPI_ADR_ADDR_UPP, 8'ha5);
            wr(hpi_pkg::HPI_ADR_ADDR_MID, 8'h3c);
            wr(hpi_pkg::HPI_ADR_ADDR_LOW, 8'h05);
            wr(hpi_pkg::HPI_ADR_DATA_HI, 8'h12);
            wr(hpi_pkg::HPI_ADR_DATA_LO, {6'h0d, we});
            wr(hpi_pkg::HPI_ADR_CONTROL, {1'b1, we, 5'h0b});
            poll();
            chk("address", {1'b1, 8'ha5, 8'h3c, 3'h5, 5'h0b},
                cap.addr);
            chk("lanes", {30'h0, we}, {30'h0, cap.we});
            chk("wdata", {8'h12, 6'h0d, we}, cap.wdata);
        end
    endtask
    task automatic t_ext_read();
        ext_rdata_i = 16'hbeef;
        wr(hpi_pkg::HPI_ADR_CONTROL, 8'h9f);
        poll();
        chk("read code", {30'h0, hpi_pkg::HPI_WE_READ},
            {30'h0, cap.we});
        rd(hpi_pkg::HPI_ADR_DATA_HI, 8'hbe);
        rd(hpi_pkg::HPI_ADR_DATA_LO, 8'hef);
    endtask
    task automatic t_irq();
        wr(hpi_pkg::HPI_ADR_INT_EN, 8'h19);
        group_status_i = 3'h6;
        wait_chk("irq masked", 1'b0);
        rd(hpi_pkg::HPI_ADR_SUMMARY, 8'h00);
        cell_sent_i = 1'b1;
        control_cell_waiting_i = 1'b1;
        wait_chk("irq cells", 1'b1);
        rd(hpi_pkg::HPI_ADR_SUMMARY, 8'h18);
        group_status_i = 3'h7;
        rd(hpi_pkg::HPI_ADR_SUMMARY, 8'h19);
        group_status_i = 3'h0;
        cell_sent_i = 1'b0;
        control_cell_waiting_i = 1'b0;
        wait_chk("irq cleared", 1'b0);
    endtask
    task automatic t_strobe_mux();
        rst(1'b1, 1'b1);
        chk("irq rest", 32'h1, {31'h0, irq_o});
        wr(hpi_pkg::HPI_ADR_DATA_HI, 8'h5a);
        rd(hpi_pkg::HPI_ADR_DATA_HI, 8'h5a);
        wr(hpi_pkg::HPI_ADR_INT_EN, 8'h01);
        group_status_i = 3'h1;
        wait_chk("irq low", 1'b0);
        group_status_i = 3'h0;
    endtask
    task automatic t_mode(input logic s, m);
        rst(s, m);
        wr(hpi_pkg::HPI_ADR_DATA_LO, 8'hc3);
        rd(hpi_pkg::HPI_ADR_DATA_LO, 8'hc3);
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        rst(1'b0, 1'b0);
        rd(8'h00, 8'h00);
        rd(8'hff, 8'h00);
        t_ext_write();
        t_ext_read();
        t_irq();
        t_strobe_mux();
        t_mode(1'b0, 1'b1);
        t_mode(1'b1, 1'b0);
        stop_test();
    end
endmodule
